// File: hdl/csg_pkg.sv
// Shared constants and carrier types for the code security gate
package csg_pkg;
    localparam int CSG_PWD_BITS = 128;
    localparam int CSG_PWD_WORDS = 8;
    localparam int CSG_EMU_BITS = 64;
    localparam logic [4:0] CSG_PWD_WAIT = 5'h10;
    localparam logic [21:0] CSG_PWD_BASE = 22'h3F7FF8;
    localparam logic [21:0] CSG_PWD_LAST = 22'h3F7FFF;
    localparam logic [21:0] CSG_FLASH_LO = 22'h3F0000;
    localparam logic [21:0] CSG_FLASH_HI = 22'h3F7FFF;
    localparam logic [21:0] CSG_OTP_LO = 22'h3D7800;
    localparam logic [21:0] CSG_OTP_HI = 22'h3D7BFF;
    localparam logic [21:0] CSG_RAM0_LO = 22'h008000;
    localparam logic [21:0] CSG_RAM0_HI = 22'h0087FF;
    localparam logic [21:0] CSG_RAM1_LO = 22'h008800;
    localparam logic [21:0] CSG_RAM1_HI = 22'h008BFF;

    typedef enum logic [1:0] {
        CSG_SRC_CPU,
        CSG_SRC_DEBUG,
        CSG_SRC_EXT,
        CSG_SRC_BOOT
    } csg_src_t;

    // One memory access presented to the gate
    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        csg_src_t src;
        logic [21:0] addr;
    } csg_req_t;

    // Key register write
    typedef struct packed {
        logic valid;
        logic [2:0] index;
        logic [15:0] data;
    } csg_key_t;
endpackage : csg_pkg

// File: hdl/csg_region.sv
// Address decoder for the protected region
`timescale 1ns/1ns
`default_nettype none
module csg_region (
    // Address in
    input wire logic [21:0] addr,
    // Region hits
    output logic in_region,
    output logic in_emu_area,
    output logic in_pwd
);
    import csg_pkg::*;
    logic hit_flash;
    logic hit_otp;
    logic hit_ram0;
    logic hit_ram1;
    always_comb begin
        hit_flash = (addr >= CSG_FLASH_LO) && (addr <= CSG_FLASH_HI);
        hit_otp = (addr >= CSG_OTP_LO) && (addr <= CSG_OTP_HI);
        hit_ram0 = (addr >= CSG_RAM0_LO) && (addr <= CSG_RAM0_HI);
        hit_ram1 = (addr >= CSG_RAM1_LO) && (addr <= CSG_RAM1_HI);
        in_region = hit_flash | hit_otp | hit_ram0 | hit_ram1;
        in_emu_area = hit_flash | hit_otp | hit_ram0;
        in_pwd = (addr >= CSG_PWD_BASE) && (addr <= CSG_PWD_LAST);
    end
endmodule : csg_region
`default_nettype wire

// File: hdl/csg_gate.sv
// Code security gate: password compare, access blocking and emulation guard
`timescale 1ns/1ns
`default_nettype none
module csg_gate (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Memory access
    input wire csg_pkg::csg_req_t req,
    input wire logic [15:0] rdata,
    // Key writes
    input wire csg_pkg::csg_key_t key_wr,
    // Emulator presence pin
    input wire logic emu_present,
    // Results
    output logic grant,
    output logic block,
    output logic busy,
    output logic unlocked,
    output logic emu_ok,
    output logic emu_cut
);
    import csg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] pwd_q [CSG_PWD_WORDS];
    logic [15:0] key_q [CSG_PWD_WORDS];
    logic [CSG_PWD_WORDS-1:0] eq;
    logic [CSG_PWD_WORDS-1:0] ones;
    logic [CSG_PWD_WORDS-1:0] zeros;
    logic [CSG_PWD_WORDS-1:0] seen_q;
    logic in_region;
    logic in_emu_area;
    logic in_pwd;
    logic emu_s1_q;
    logic emu_s2_q;
    logic [4:0] wait_q;
    logic pend_q;
    logic pend_pwd_q;
    logic [2:0] pend_idx_q;
    logic full_match;
    logic low_match;
    logic all_ones;
    logic eval_q;
    logic secure;

    csg_region u_region (
        .addr(req.addr),
        .in_region(in_region),
        .in_emu_area(in_emu_area),
        .in_pwd(in_pwd)
    );

    genvar gi;
    generate
        for (gi = 0; gi < CSG_PWD_WORDS; gi++) begin : g_cmp
            assign eq[gi] = (key_q[gi] == pwd_q[gi]);
            assign ones[gi] = (pwd_q[gi] == 16'hFFFF);
            assign zeros[gi] = (pwd_q[gi] == 16'h0000);
        end
    endgenerate
    // Unread words or an all-zero password never match, so a zero key opens the gate only when the password is all ones
    assign full_match = &eq && &seen_q && !(&zeros);
    assign low_match = &eq[CSG_EMU_BITS/16-1:0] && &seen_q[CSG_EMU_BITS/16-1:0] && !(&zeros);
    assign all_ones = &ones;

    ////////////////////////////////////////////////////////////////////////
    // Emulator pin synchroniser
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            emu_s1_q <= 1'b0;
            emu_s2_q <= 1'b0;
        end else begin
            emu_s1_q <= emu_present;
            emu_s2_q <= emu_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Password access waits a fixed 16 states, then captures the word
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wait_q <= 5'h00;
            pend_q <= 1'b0;
            pend_pwd_q <= 1'b0;
            pend_idx_q <= 3'h0;
        end else if (pend_q) begin
            if (wait_q == 5'h00) begin
                pend_q <= 1'b0;
                pend_pwd_q <= 1'b0;
            end else begin
                wait_q <= wait_q - 5'h01;
            end
        end else if (req.valid && in_pwd && !req.write) begin
            pend_q <= 1'b1;
            pend_pwd_q <= 1'b1;
            pend_idx_q <= req.addr[2:0];
            wait_q <= CSG_PWD_WAIT;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < CSG_PWD_WORDS; i++) begin
                pwd_q[i] <= 16'h0000;
            end
            seen_q <= '0;
        end else if (pend_q && pend_pwd_q && wait_q == 5'h00) begin
            pwd_q[pend_idx_q] <= rdata;
            seen_q[pend_idx_q] <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < CSG_PWD_WORDS; i++) begin
                key_q[i] <= 16'h0000;
            end
        end else if (key_wr.valid) begin
            key_q[key_wr.index] <= key_wr.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock state re-evaluated only after a password read or key write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            eval_q <= 1'b0;
        end else begin
            eval_q <= key_wr.valid || (pend_q && wait_q == 5'h00);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            unlocked <= 1'b0;
            emu_ok <= 1'b0;
        end else if (eval_q) begin
            unlocked <= full_match || all_ones;
            emu_ok <= low_match || all_ones;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access decisions
    always_comb begin
        secure = !unlocked && in_region;
        if (req.src == CSG_SRC_EXT) begin
            secure = !unlocked && req.fetch;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            grant <= 1'b0;
            block <= 1'b0;
            busy <= 1'b0;
        end else begin
            busy <= pend_q || (req.valid && in_pwd && !req.write);
            grant <= req.valid && !secure && !in_pwd;
            block <= req.valid && secure && req.src != CSG_SRC_CPU;
        end
    end

    // Emulation guard: sticky until reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            emu_cut <= 1'b0;
        end else if (emu_s2_q && req.valid && in_emu_area && !emu_ok) begin
            emu_cut <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_pwd_wait_len: assert property (@(posedge mclk) disable iff (!rst_n)
        (!pend_q && req.valid && in_pwd && !req.write) |=> pend_q [*8] ##0 (wait_q == 5'h09))
        else $error("password wait count wrong");
    a_debug_block: assert property (@(posedge mclk) disable iff (!rst_n)
        (req.valid && req.src == CSG_SRC_DEBUG && in_region && !unlocked) |=> block)
        else $error("debug read of locked region not blocked");
    a_key_unlock: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(unlocked) |-> $past(full_match || all_ones))
        else $error("unlock without match");
    a_emu_trip: assert property (@(posedge mclk) disable iff (!rst_n)
        (emu_s2_q && req.valid && in_emu_area && !emu_ok) |=> emu_cut)
        else $error("emulation guard did not trip");
    a_emu_low_only: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(emu_ok) |-> $past(low_match || all_ones))
        else $error("debug allowed without low match");
    a_blank_open: assert property (@(posedge mclk) disable iff (!rst_n)
        (eval_q && all_ones) |=> unlocked)
        else $error("blank password left locked");
    a_lock_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !eval_q |=> $stable(unlocked))
        else $error("lock changed without evaluation");
    a_region_grant: assert property (@(posedge mclk) disable iff (!rst_n)
        (req.valid && in_region && !in_pwd && !unlocked && req.src != CSG_SRC_EXT) |=> !grant)
        else $error("locked region granted");
    a_unread_lock: assert property (@(posedge mclk) disable iff (!rst_n)
        (eval_q && !(&seen_q)) |=> !unlocked)
        else $error("unlocked before the whole password was read");
    a_ext_fetch: assert property (@(posedge mclk) disable iff (!rst_n)
        (req.valid && req.src == CSG_SRC_EXT && req.fetch && !unlocked) |=> block)
        else $error("external fetch not blocked while locked");
    a_cut_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
        emu_cut |=> emu_cut)
        else $error("emulation cut released without reset");
    c_unlock: cover property (@(posedge mclk) disable iff (!rst_n) $rose(unlocked));
    c_emu_cut: cover property (@(posedge mclk) disable iff (!rst_n) $rose(emu_cut));
    c_emu_only: cover property (@(posedge mclk) disable iff (!rst_n) emu_ok && !unlocked);
    c_blank_open: cover property (@(posedge mclk) disable iff (!rst_n) eval_q && all_ones);
endmodule : csg_gate
`default_nettype wire

// File: bench/csg_flash_model.sv
// Flash model that serves the password words behind fixed wait states
`timescale 1ns/1ns
`default_nettype none
module csg_flash_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Access side
    input wire csg_pkg::csg_req_t req,
    input wire logic busy,
    input wire logic blank,
    // Password word
    output logic [15:0] rdata
);
    import csg_pkg::*;
    logic [2:0] idx_q;
    logic [4:0] cnt_q;
    logic [15:0] word;
    // Programmed words are never all zero
    assign word = blank ? 16'hFFFF : 16'h1357 + {13'h0, idx_q};
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= 5'h00;
            idx_q <= 3'h0;
        end else if (req.valid && !busy && !req.write && req.addr >= CSG_PWD_BASE && req.addr <= CSG_PWD_LAST) begin
            idx_q <= req.addr[2:0];
            cnt_q <= CSG_PWD_WAIT + 5'h01;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end
    // Word is only valid in the cycle the wait runs out
    assign rdata = (cnt_q == 5'h01) ? word : ~word;
endmodule : csg_flash_model
`default_nettype wire

// File: bench/code_security_gate_test.sv
// Self-checking bench for the code security gate
`timescale 1ns/1ns
`default_nettype none
module code_security_gate_test;
    import csg_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic emu_present = 1'b0;
    logic blank = 1'b0;
    csg_req_t req = '0;
    csg_key_t key_wr = '0;
    logic [15:0] rdata;
    logic grant, block, busy, unlocked, emu_ok, emu_cut;
    logic [5:0] exp_q[$];
    logic [31:0] seed = 32'h0000B51C;
    int bad_count = 0;
    int samples_checked = 0;
    // Zero-filled words below the boot entry, and the data-only words just below it
    localparam logic [21:0] FILL_LO = 22'h3F7F80;
    localparam logic [21:0] DATA_LO = 22'h3F7FF0;
    event ev;
    always #5 mclk = ~mclk;
    csg_gate dut_u (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .key_wr(key_wr),
        .emu_present(emu_present), .grant(grant), .block(block), .busy(busy), .unlocked(unlocked),
        .emu_ok(emu_ok), .emu_cut(emu_cut));
    csg_flash_model flash_u (.mclk(mclk), .rst_n(rst_n), .req(req), .busy(busy), .blank(blank), .rdata(rdata));
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : rnd
    function automatic logic [15:0] pw(input int i);
        return 16'h1357 + 16'(i);
    endfunction : pw
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // Expected {grant, block, busy, unlocked, emu_ok, emu_cut}
    task automatic chk(input logic [5:0] e);
        #1;
        exp_q.push_back(e);
        ->ev;
    endtask : chk
    always begin
        @(ev);
        samples_checked++;
        if ({grant, block, busy, unlocked, emu_ok, emu_cut} !== exp_q[0]) begin
            bad_count++;
            $display("MISMATCH outputs exp %b seen %b", exp_q[0], {grant, block, busy, unlocked, emu_ok, emu_cut});
        end
        void'(exp_q.pop_front());
    end
    task automatic do_reset();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
    endtask : do_reset
    task automatic access(input csg_src_t s, input logic f, input logic [21:0] a, input logic [5:0] e);
        @(posedge mclk);
        req <= {1'b1, 1'b0, f, s, a};
        @(posedge mclk);
        req.valid <= 1'b0;
        // Grant and block stand for one cycle after the taking edge
        chk(e);
    endtask : access
    task automatic pwd_read(input int i, input logic [2:0] p, input logic [2:0] e);
        access(CSG_SRC_CPU, 1'b0, CSG_PWD_BASE + 22'(i), {3'b001, p});
        repeat (15) @(posedge mclk);
        chk({3'b001, p});
        repeat (3) @(posedge mclk);
        chk({3'b000, e});
    endtask : pwd_read
    task automatic key(input int i, input logic [15:0] d);
        @(posedge mclk);
        key_wr <= {1'b1, 3'(i), d};
        @(posedge mclk);
        key_wr.valid <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : key
    initial begin
        do_reset();
        chk(6'b000000);
        access(CSG_SRC_DEBUG, 1'b0, CSG_FLASH_LO, 6'b010000);
        access(CSG_SRC_BOOT, 1'b0, CSG_OTP_LO, 6'b010000);
        access(CSG_SRC_DEBUG, 1'b0, CSG_RAM1_LO, 6'b010000);
        access(CSG_SRC_EXT, 1'b1, CSG_RAM1_HI, 6'b010000);
        access(CSG_SRC_DEBUG, 1'b0, FILL_LO + 22'(rnd() & 16'h003F), 6'b010000);
        access(CSG_SRC_CPU, 1'b0, CSG_RAM0_LO, 6'b000000);
        for (int i = 0; i < 8; i++) begin
            pwd_read(i, 3'b000, 3'b000);
        end
        for (int i = 0; i < 4; i++) begin
            key(i, pw(i));
        end
        chk(6'b000010);
        key(7, pw(7) ^ (rnd() | 16'h0001));
        chk(6'b000010);
        for (int i = 4; i < 8; i++) begin
            key(i, pw(i));
        end
        chk(6'b000110);
        key(0, pw(0) ^ (rnd() | 16'h0001));
        chk(6'b000000);
        key(0, pw(0));
        chk(6'b000110);
        access(CSG_SRC_DEBUG, 1'b0, CSG_FLASH_LO + 22'(rnd() & 16'h7EFF), 6'b100110);
        access(CSG_SRC_EXT, 1'b1, CSG_OTP_LO + 22'(rnd() & 16'h03FF), 6'b100110);
        @(posedge mclk);
        emu_present <= 1'b1;
        repeat (3) @(posedge mclk);
        access(CSG_SRC_CPU, 1'b0, CSG_FLASH_HI - 22'h000010, 6'b100110);
        do_reset();
        chk(6'b000000);
        repeat (3) @(posedge mclk);
        access(CSG_SRC_CPU, 1'b1, CSG_RAM0_HI, 6'b000001);
        repeat (2) @(posedge mclk);
        chk(6'b000001);
        @(posedge mclk);
        emu_present <= 1'b0;
        blank <= 1'b1;
        do_reset();
        for (int i = 0; i < 8; i++) begin
            pwd_read(i, 3'b000, (i == 7) ? 3'b110 : 3'b000);
        end
        access(CSG_SRC_CPU, 1'b0, DATA_LO + 22'(rnd() & 16'h0003), 6'b100110);
        wrap_up();
    end
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
endmodule : code_security_gate_test
`default_nettype wire
